// [design/mtc_core.sv]
// Five-channel timer core: counters, general registers, flags, run control
`timescale 1ns/1ns
module mtc_core import mtc_pkg::*; (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          hw_standby,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata,
    input  wire logic [19:0]   capture_evt,
    input  wire logic [4:0]    xfer_act_a,
    input  wire logic [4:0]    xfer_act_b,
    input  wire logic [4:0]    flag_clear_disable_select_a,
    input  wire logic [4:0]    flag_clear_disable_select_b,
    output logic      [4:0]    match_a_interrupt,
    output logic      [4:0]    match_b_interrupt,
    output logic      [4:0]    timer_io_pin_o,
    output logic      [4:0]    timer_io_pin_oe
);
    logic [DW-1:0]    cnt_r [NCH];
    logic [7:0]       run_r;
    logic [IOC_W-1:0] ioc_r [NCH];
    logic [4:0]       pin_r;
    logic [4:0]       running;
    logic [NGR-1:0]   g_wen;
    logic [NGR*DW-1:0] g_wdat;
    logic [NGR*DW-1:0] g_all;
    logic [DW-1:0]    g_q;
    logic [19:0]      ev_cmp;
    logic [19:0]      ev_cap;
    logic [19:0]      flag_set;
    logic [19:0]      flag;
    logic [19:0]      armed;
    logic [4:0]       wr_cnt;
    logic [4:0]       wr_stat;
    logic [4:0]       rd_stat;
    logic [4:0]       wr_ioc;
    logic             wr_run;
    logic             g_hit_wr;
    logic [3:0]       g_idx;
    mtc_rsel_t        rsel_r;
    logic [DW-1:0]    rdata_r;

    // Bus address decode
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            wr_cnt[c]  = reg_wr && (reg_addr == OFS_CNT + 8'(c));
            wr_stat[c] = reg_wr && (reg_addr == OFS_STAT + 8'(c));
            rd_stat[c] = reg_rd && (reg_addr == OFS_STAT + 8'(c));
            wr_ioc[c]  = reg_wr && (reg_addr == OFS_IOC + 8'(c));
            running[c] = run_r[run_pos(c)];
        end
    end
    assign wr_run   = reg_wr && (reg_addr == OFS_RUN);
    assign g_hit_wr = reg_wr && greg_valid(reg_addr);
    assign g_idx    = greg_index(reg_addr);

    // Channel counters: standby, bus write, then count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NCH; c++) cnt_r[c] <= CNT_RST;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (hw_standby)      cnt_r[c] <= CNT_RST;
                else if (wr_cnt[c])  cnt_r[c] <= reg_wdata;
                else if (running[c]) cnt_r[c] <= cnt_r[c] + 16'h0001;
            end
        end
    end

    // Run control, reserved bits kept at zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)      run_r <= RUN_RST;
        else if (wr_run) run_r <= reg_wdata[7:0] & RUN_MASK;
    end

    // Per-channel I/O control: capture select, pin enable, initial level, buffering
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NCH; c++) ioc_r[c] <= IOC_RST;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_ioc[c]) ioc_r[c] <= reg_wdata[IOC_W-1:0];
            end
        end
    end

    // Pin level: initial value when stopped, toggle on compare match A
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_r <= 5'h00;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_ioc[c] && !running[c])
                    pin_r[c] <= reg_wdata[IOC_INIT];
                else if (ev_cmp[c*4] && ioc_r[c][IOC_OE])
                    pin_r[c] <= ~pin_r[c];                             // match A: toggled
            end
        end
    end
    assign timer_io_pin_o = pin_r;
    always_comb begin
        for (int c = 0; c < NCH; c++) timer_io_pin_oe[c] = ioc_r[c][IOC_OE];
    end

    // Per-register events, write enables and flags
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        for (genvar r = 0; r < 4; r++) begin : g_reg
            if (r < 2 || has_cd(c)) begin : g_on
                localparam int GI = greg_base(c) + r;
                logic          cm;
                logic          buf_on;
                logic          bus_hit;
                logic [DW-1:0] word;
                assign cm      = ioc_r[c][r];
                assign buf_on  = has_cd(c) && ioc_r[c][IOC_BUF];
                assign bus_hit = g_hit_wr && (g_idx == 4'(GI));
                assign word    = g_all[GI*DW +: DW];
                // Compare while counting, capture on the input event
                assign ev_cmp[c*4+r] = running[c] && !cm && (cnt_r[c] == word);
                assign ev_cap[c*4+r] = cm && capture_evt[c*4+r];
                if (r < 2) begin : g_ab
                    // A/B: capture loads counter; buffered compare reloads from C/D
                    assign g_wen[GI]  = bus_hit || ev_cap[c*4+r] || (buf_on && ev_cmp[c*4+r]);
                    assign g_wdat[GI*DW +: DW] = bus_hit ? reg_wdata :
                                                 cm ? cnt_r[c] : g_all[(GI+2)*DW +: DW];
                    assign flag_set[c*4+r] = ev_cmp[c*4+r] || ev_cap[c*4+r];
                end else begin : g_cd
                    // C/D: own capture, or buffer of the old A/B value
                    assign g_wen[GI]  = bus_hit || (!buf_on && ev_cap[c*4+r]) ||
                                        (buf_on && ev_cap[c*4+r-2]);
                    assign g_wdat[GI*DW +: DW] = bus_hit ? reg_wdata :
                                                 buf_on ? g_all[(GI-2)*DW +: DW] : cnt_r[c];
                    assign flag_set[c*4+r] = !buf_on && (ev_cmp[c*4+r] || ev_cap[c*4+r]);
                end
                mtc_flag_cell u_flag (
                    .core_clk (core_clk),
                    .rst_n    (rst_n),
                    .set_i    (flag_set[c*4+r]),
                    .rd_i     (rd_stat[c]),
                    .wr_i     (wr_stat[c]),
                    .wbit_i   (reg_wdata[r]),
                    .hw_clr_i ((r == 0) ? (xfer_act_a[c] && !flag_clear_disable_select_a[c]) :
                               (r == 1) ? (xfer_act_b[c] && !flag_clear_disable_select_b[c]) : 1'b0),
                    .flag_r   (flag[c*4+r]),
                    .armed_r  (armed[c*4+r])
                );
            end else begin : g_off
                // Absent C/D on channels 1 and 2 read as zero
                assign ev_cmp[c*4+r]   = 1'b0;
                assign ev_cap[c*4+r]   = 1'b0;
                assign flag_set[c*4+r] = 1'b0;
                assign flag[c*4+r]     = 1'b0;
                assign armed[c*4+r]    = 1'b0;
            end
        end
        assign match_a_interrupt[c] = flag[c*4];
        assign match_b_interrupt[c] = flag[c*4+1];
    end

    mtc_greg_mem #(
        .W (DW),
        .N (NGR)
    ) u_mem (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .wen       (g_wen),
        .wdat      (g_wdat),
        .raddr     (g_idx),
        .q         (g_q),
        .all_words (g_all)
    );

    // Read path: data valid in the cycle after the strobe, unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsel_r  <= RS_NONE;
            rdata_r <= 16'h0000;
        end else begin
            rsel_r  <= RS_NONE;
            rdata_r <= 16'h0000;
            if (reg_rd) begin
                if (greg_valid(reg_addr)) begin
                    rsel_r <= RS_MEM;
                end else begin
                    rsel_r <= RS_REG;
                    for (int c = 0; c < NCH; c++) begin
                        if (reg_addr == OFS_CNT + 8'(c))  rdata_r <= cnt_r[c];
                        if (reg_addr == OFS_STAT + 8'(c)) rdata_r <= {12'h000, flag[c*4 +: 4]};
                        if (reg_addr == OFS_IOC + 8'(c))  rdata_r <= {9'h000, ioc_r[c]};
                    end
                    if (reg_addr == OFS_RUN) rdata_r <= {8'h00, run_r};
                end
            end
        end
    end
    assign reg_rdata = (rsel_r == RS_MEM) ? g_q : rdata_r;

    // Checks on the logic above
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Counters, run register and register reads
    a_cnt_standby_zero: assert property (
        hw_standby
        |=> cnt_r[0] == 16'h0000 && cnt_r[4] == 16'h0000)
        else $error("counter not zero in standby");

    a_standby_mid_zero: assert property (
        hw_standby
        |=> cnt_r[1] == 16'h0000 && cnt_r[2] == 16'h0000 && cnt_r[3] == 16'h0000)
        else $error("middle counter not zero in standby");

    a_cnt_bus_write: assert property (
        wr_cnt[0] && !hw_standby
        |=> cnt_r[0] == $past(reg_wdata))
        else $error("counter write did not land");

    a_cnt_counts_up: assert property (
        running[3] && !hw_standby && !wr_cnt[3]
        |=> cnt_r[3] == $past(cnt_r[3]) + 16'h0001)
        else $error("running counter did not advance by one");

    a_cnt_halt_hold: assert property (
        !running[1] && !hw_standby && !wr_cnt[1]
        |=> $stable(cnt_r[1]))
        else $error("stopped counter moved");

    a_run_write: assert property (
        wr_run
        |=> run_r == ($past(reg_wdata[7:0]) & RUN_MASK))
        else $error("run register write did not land");

    a_read_cnt_data: assert property (
        reg_rd && reg_addr == OFS_CNT
        |=> reg_rdata == $past(cnt_r[0]))
        else $error("counter read returned wrong data");

    a_run_rsvd_zero: assert property (
        reg_rd && reg_addr == OFS_RUN
        |=> reg_rdata[5:3] == 3'h0)
        else $error("reserved run bits read nonzero");

    // Flag setting, clearing and absent flags
    a_flag_a_set: assert property (
        running[0] && !ioc_r[0][0] && cnt_r[0] == g_all[15:0]
        |=> match_a_interrupt[0])
        else $error("compare match A did not set flag");

    a_flag_b_set: assert property (
        running[0] && !ioc_r[0][1] && cnt_r[0] == g_all[DW +: DW]
        |=> match_b_interrupt[0])
        else $error("compare match B did not set flag");

    a_cd_flag_c: assert property (
        running[0] && !ioc_r[0][2] && !ioc_r[0][IOC_BUF] && cnt_r[0] == g_all[2*DW +: DW]
        |=> flag[2])
        else $error("compare match C did not set flag");

    a_flag_a_capture: assert property (
        ioc_r[1][0] && capture_evt[4] && !g_hit_wr
        |=> match_a_interrupt[1] && g_all[4*DW +: DW] == $past(cnt_r[1]))
        else $error("capture A did not load counter or set flag");

    a_flag_b_capture: assert property (
        ioc_r[1][1] && capture_evt[5] && !g_hit_wr
        |=> match_b_interrupt[1] && g_all[5*DW +: DW] == $past(cnt_r[1]))
        else $error("capture B did not load counter or set flag");

    a_write_no_set: assert property (
        !flag[0] && !flag_set[0] && wr_stat[0]
        |=> !flag[0])
        else $error("bus write set a flag");

    a_armed_on_read: assert property (
        rd_stat[0] && flag[0] && !wr_stat[0]
        |=> armed[0])
        else $error("read of a set flag did not arm clearing");

    a_disarm_on_write: assert property (
        wr_stat[0]
        |=> !armed[0])
        else $error("status write did not disarm clearing");

    a_flag_clr_seq: assert property (
        flag[0] && armed[0] && wr_stat[0] && !reg_wdata[0] && !flag_set[0]
        |=> !flag[0])
        else $error("read-then-write-0 did not clear");

    a_flag_unarmed_keep: assert property (
        flag[1] && !armed[1] && wr_stat[0] && !xfer_act_b[0]
        |=> flag[1])
        else $error("flag cleared without prior read");

    a_xfer_clr_a: assert property (
        flag[4] && xfer_act_a[1] && !flag_clear_disable_select_a[1] && !flag_set[4]
        |=> !flag[4])
        else $error("transfer activation did not clear flag A");

    a_xfer_clr_b: assert property (
        flag[5] && xfer_act_b[1] && !flag_clear_disable_select_b[1] && !flag_set[5]
        |=> !flag[5])
        else $error("transfer activation did not clear flag B");

    a_xfer_dsel_keep: assert property (
        flag[4] && xfer_act_a[1] && flag_clear_disable_select_a[1] && !wr_stat[1]
        |=> flag[4])
        else $error("disabled transfer activation cleared flag");

    a_set_wins_clr: assert property (
        flag_set[4] && xfer_act_a[1]
        |=> flag[4])
        else $error("set lost against clear");

    a_cd_absent_zero: assert property (
        reg_rd && reg_addr == OFS_STAT + 8'h01
        |=> reg_rdata[3:2] == 2'h0)
        else $error("absent flags C/D read nonzero");

    // Buffer mode on channel 0
    a_buf_reload: assert property (
        running[0] && ioc_r[0][IOC_BUF] && !ioc_r[0][0] && cnt_r[0] == g_all[15:0] && !g_hit_wr
        |=> g_all[15:0] == $past(g_all[2*DW +: DW]))
        else $error("buffered compare did not reload A from C");

    a_buf_no_cd: assert property (
        ioc_r[0][IOC_BUF] && !flag[2]
        |=> !flag[2])
        else $error("buffer register raised its own flag");

    // Timer pin of channel 2
    a_pin_init_lvl: assert property (
        wr_ioc[2] && !running[2]
        |=> timer_io_pin_o[2] == $past(reg_wdata[IOC_INIT]))
        else $error("stopped pin did not take initial level");

    a_pin_hold_stop: assert property (
        !running[2] && !wr_ioc[2]
        |=> $stable(timer_io_pin_o[2]))
        else $error("stopped pin changed level");

    a_pin_toggle: assert property (
        ev_cmp[8] && ioc_r[2][IOC_OE]
        |=> timer_io_pin_o[2] != $past(timer_io_pin_o[2]))
        else $error("compare match A did not toggle pin");

    // Main scenarios reached
    c_match_a:  cover property (match_a_interrupt[0] && armed[0] ##1 wr_stat[0]);
    c_capture:  cover property (ev_cap[4] ##[1:20] xfer_act_a[1]);
    c_buffered: cover property (ioc_r[0][IOC_BUF] && ev_cmp[0]);
    c_standby:  cover property (hw_standby ##[1:12] running[0]);
endmodule

// [design/mtc_pkg.sv]
// Constants, address map and helpers for the five-channel timer core
package mtc_pkg;
    localparam int          NCH       = 5;
    localparam int          NGR       = 16;
    localparam int          DW        = 16;
    localparam int          AW        = 8;
    localparam logic [7:0]  OFS_CNT   = 8'h00;
    localparam logic [7:0]  OFS_GREG  = 8'h10;
    localparam logic [7:0]  GREG_SPAN = 8'h14;
    localparam logic [7:0]  OFS_STAT  = 8'h30;
    localparam logic [7:0]  OFS_IOC   = 8'h38;
    localparam logic [7:0]  OFS_RUN   = 8'h40;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] GREG_RST  = 16'hFFFF;
    localparam logic [7:0]  RUN_RST   = 8'h00;
    localparam logic [7:0]  RUN_MASK  = 8'hC7;
    localparam int          IOC_W     = 7;
    localparam logic [6:0]  IOC_RST   = 7'h00;
    localparam int          IOC_OE    = 4;
    localparam int          IOC_INIT  = 5;
    localparam int          IOC_BUF   = 6;

    typedef enum logic [1:0] {RS_NONE, RS_REG, RS_MEM} mtc_rsel_t;

    // First general register index of a channel
    function automatic int greg_base(input int ch);
        case (ch)
            0: greg_base = 0;
            1: greg_base = 4;
            2: greg_base = 6;
            3: greg_base = 8;
            default: greg_base = 12;
        endcase
    endfunction

    // Channels that own registers C and D
    function automatic logic has_cd(input int ch);
        has_cd = (ch == 0) || (ch == 3) || (ch == 4);
    endfunction

    // Bit of the run register that belongs to a channel
    function automatic int run_pos(input int ch);
        run_pos = (ch < 3) ? ch : ch + 3;
    endfunction

    // True when an address hits an existing general register
    function automatic logic greg_valid(input logic [7:0] a);
        logic [7:0] off;
        off = a - OFS_GREG;
        greg_valid = (a >= OFS_GREG) && (off < GREG_SPAN) &&
                     (has_cd(int'(off[4:2])) || !off[1]);
    endfunction

    // General register index addressed by a bus address
    function automatic logic [3:0] greg_index(input logic [7:0] a);
        logic [7:0] off;
        off = a - OFS_GREG;
        greg_index = 4'(greg_base(int'(off[4:2])) + int'(off[1:0]));
    endfunction
endpackage

// [design/mtc_greg_mem.sv]
// General register storage with parallel view and registered read port
`timescale 1ns/1ns
module mtc_greg_mem import mtc_pkg::*; #(
    parameter int W = DW,
    parameter int N = NGR
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [N-1:0]         wen,
    input  wire logic [N*W-1:0]       wdat,
    input  wire logic [$clog2(N)-1:0] raddr,
    output logic      [W-1:0]         q,
    output logic      [N*W-1:0]       all_words
);
    logic [W-1:0] mem_r [N];

    // Word storage, all ones after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) mem_r[i] <= W'(GREG_RST);
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wen[i]) mem_r[i] <= wdat[i*W +: W];
            end
        end
    end

    // Registered read port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) q <= W'(GREG_RST);
        else        q <= mem_r[raddr];
    end

    // Parallel view for comparators and buffer moves
    always_comb begin
        for (int i = 0; i < N; i++) all_words[i*W +: W] = mem_r[i];
    end
endmodule

// [design/mtc_flag_cell.sv]
// One capture/compare status flag with read-then-write-0 clearing
`timescale 1ns/1ns
module mtc_flag_cell (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic set_i,
    input  wire logic rd_i,
    input  wire logic wr_i,
    input  wire logic wbit_i,
    input  wire logic hw_clr_i,
    output logic      flag_r,
    output logic      armed_r
);
    // Remember that software saw the flag as 1
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)                armed_r <= 1'b0;
        else if (wr_i)             armed_r <= 1'b0;
        else if (rd_i && flag_r)   armed_r <= 1'b1;
    end

    // Set wins over any clear; writes only clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)                           flag_r <= 1'b0;
        else if (set_i)                       flag_r <= 1'b1;
        else if (wr_i && !wbit_i && armed_r)  flag_r <= 1'b0;
        else if (hw_clr_i)                    flag_r <= 1'b0;
    end
endmodule

// [verification/tb.sv]
// Self-checking testbench for the five-channel timer core
`timescale 1ns/1ns
module tb import mtc_pkg::*;;
    logic          core_clk;
    logic          rst_n;
    logic          hw_standby;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    logic [DW-1:0] reg_rdata;
    logic [19:0]   capture_evt;
    logic [4:0]    xfer_act_a;
    logic [4:0]    xfer_act_b;
    logic [4:0]    dsel_a;
    logic [4:0]    dsel_b;
    logic [4:0]    irq_a;
    logic [4:0]    irq_b;
    logic [4:0]    pin_o;
    logic [4:0]    pin_oe;
    logic [15:0]   rv;
    int            num_errors;
    int            num_checks;
    int            cycles;
    logic [7:0]    run_bits [5] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h80};

    mtc_core i_mtc_core (
        .core_clk                    (core_clk),
        .rst_n                       (rst_n),
        .hw_standby                  (hw_standby),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_wr                      (reg_wr),
        .reg_rd                      (reg_rd),
        .reg_rdata                   (reg_rdata),
        .capture_evt                 (capture_evt),
        .xfer_act_a                  (xfer_act_a),
        .xfer_act_b                  (xfer_act_b),
        .flag_clear_disable_select_a (dsel_a),
        .flag_clear_disable_select_b (dsel_b),
        .match_a_interrupt           (irq_a),
        .match_b_interrupt           (irq_b),
        .timer_io_pin_o              (pin_o),
        .timer_io_pin_oe             (pin_oe)
    );

    // Clock at 125 MHz
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data stand in the following cycle only
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
        chk(rv, exp);
    endtask

    // Let a flag or pin update land, then sample
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    initial begin
        rst_n = 1'b0;
        hw_standby = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        capture_evt = 20'h00000;
        xfer_act_a = 5'h00;
        xfer_act_b = 5'h00;
        dsel_a = 5'h00;
        dsel_b = 5'h00;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values: counters, general registers, run register
        for (int c = 0; c < 5; c++) begin
            rchk(8'(c), 16'h0000);
            for (int r = 0; r < 4; r++) begin
                rchk(8'(8'h10 + c * 4 + r), (r > 1 && (c == 1 || c == 2)) ? 16'h0000 : 16'hFFFF);
            end
        end
        rchk(8'h40, 16'h0000);
        // Counters are full 16-bit read/write words
        for (int c = 0; c < 5; c++) begin
            wr(8'(c), 16'(16'h2345 * (c + 1)));
            rchk(8'(c), 16'(16'h2345 * (c + 1)));
        end
        // Reserved run bits read zero
        wr(8'h40, 16'h00FF);
        rchk(8'h40, 16'h00C7);
        wr(8'h40, 16'h0000);
        // Each run bit starts its own counter only; standby zeroes them all
        for (int c = 0; c < 5; c++) begin
            @(posedge core_clk);
            hw_standby <= 1'b1;
            repeat (2) @(posedge core_clk);
            hw_standby <= 1'b0;
            rchk(8'(c), 16'h0000);
            wr(8'h40, {8'h00, run_bits[c]});
            repeat (6) @(posedge core_clk);
            wr(8'h40, 16'h0000);
            // Run bit stands over eight counting edges, from its write to the clearing write
            rchk(8'(c), 16'h0008);
            chk({15'h0, rv === 16'h0000}, 16'h0000);
            rchk(8'((c + 1) % 5), 16'h0000);
        end
        // Compare matches on A, B, C of channel 0
        wr(8'h10, 16'h0010);
        wr(8'h11, 16'h0012);
        wr(8'h12, 16'h0014);
        wr(8'h00, 16'h0000);
        wr(8'h40, 16'h0001);
        repeat (30) @(posedge core_clk);
        wr(8'h40, 16'h0000);
        settle();
        chk({15'h0, irq_a[0]}, 16'h0001);
        chk({15'h0, irq_b[0]}, 16'h0001);
        // A clear without a preceding read leaves the flags alone
        wr(8'h30, 16'h0000);
        rchk(8'h30, 16'h0007);
        wr(8'h30, 16'h000F);
        rchk(8'h30, 16'h0007);
        wr(8'h30, 16'h0000);
        rchk(8'h30, 16'h0000);
        wr(8'h30, 16'h000F);
        rchk(8'h30, 16'h0000);
        // Capture into A and B of channel 1
        wr(8'h39, 16'h0003);
        wr(8'h01, 16'h1234);
        @(posedge core_clk);
        capture_evt <= 20'h00030;
        @(posedge core_clk);
        capture_evt <= 20'h00000;
        rchk(8'h14, 16'h1234);
        rchk(8'h15, 16'h1234);
        rchk(8'h31, 16'h0003);
        // Transfer activation clears only with disable-select low
        @(posedge core_clk);
        xfer_act_a <= 5'h02;
        dsel_a <= 5'h02;
        @(posedge core_clk);
        xfer_act_a <= 5'h00;
        dsel_a <= 5'h00;
        settle();
        chk({15'h0, irq_a[1]}, 16'h0001);
        @(posedge core_clk);
        xfer_act_a <= 5'h02;
        xfer_act_b <= 5'h02;
        @(posedge core_clk);
        xfer_act_a <= 5'h00;
        xfer_act_b <= 5'h00;
        settle();
        chk({15'h0, irq_a[1]}, 16'h0000);
        chk({15'h0, irq_b[1]}, 16'h0000);
        // A capture and a clear in the same cycle leave the flag set
        @(posedge core_clk);
        capture_evt <= 20'h00010;
        xfer_act_a <= 5'h02;
        @(posedge core_clk);
        capture_evt <= 20'h00000;
        xfer_act_a <= 5'h00;
        settle();
        chk({15'h0, irq_a[1]}, 16'h0001);
        // Pin of channel 2: initial level while stopped, level held after stop
        wr(8'h3A, 16'h0030);
        settle();
        chk({14'h0, pin_oe[2], pin_o[2]}, 16'h0003);
        wr(8'h18, 16'h0005);
        wr(8'h02, 16'h0000);
        wr(8'h40, 16'h0004);
        repeat (20) @(posedge core_clk);
        wr(8'h40, 16'h0000);
        settle();
        chk({14'h0, pin_oe[2], pin_o[2]}, 16'h0002);
        repeat (10) @(posedge core_clk);
        #1;
        chk({15'h0, pin_o[2]}, 16'h0000);
        wr(8'h3A, 16'h0030);
        settle();
        chk({15'h0, pin_o[2]}, 16'h0001);
        // Buffered compare on channel 0: match A reloads A from C, C raises no flag
        wr(8'h38, 16'h0040);
        wr(8'h10, 16'h0004);
        wr(8'h12, 16'h0009);
        wr(8'h00, 16'h0000);
        wr(8'h40, 16'h0001);
        repeat (8) @(posedge core_clk);
        wr(8'h40, 16'h0000);
        rchk(8'h00, 16'h000A);
        rchk(8'h10, 16'h0009);
        rchk(8'h30, 16'h0001);
        give_verdict();
    end
endmodule
